// >>> lfs_map.svh
`ifndef LFS_MAP_SVH
`define LFS_MAP_SVH

// =============================================================
// Clock and timing
// =============================================================
`define LFS_CLK_PERIOD_NS 8
`define LFS_TRIG_DELAY_NS 10000
`define LFS_TRIG_LEAD_NS 6500
`define LFS_TIMER_RES_NS 4
`define LFS_TIMER_W 20
`define LFS_SENSORS 4

// =============================================================
// Compare channel numbering
// =============================================================
`define LFS_CH_END 0
`define LFS_CH_BUCK 1
`define LFS_CH_SHUNT 2
`define LFS_CH_TRIG 3
`define LFS_CH_NUM 4

// =============================================================
// Reset values of the outputs and the timer start value
// =============================================================
`define LFS_BUCK_OFF_N 1'b1
`define LFS_SHUNT_OFF 1'b0
`define LFS_TIMER_START 1

`endif

// >>> lfs_pkg.sv
package lfs_pkg;

	// =========================================================
	// Sequencer states
	// =========================================================
	typedef enum logic [1:0] {
		LFS_IDLE,
		LFS_ARMED,
		LFS_FLASH
	} lfs_state_t;

endpackage

// >>> lfs_compare.sv
`timescale 1ns/1ps

// One compare channel: flags the cycle in which the running timer equals
// its match value, only while the timer is running.
module lfs_compare #(
	parameter int W = 20
) (
	input wire logic [W-1:0] count,
	input wire logic [W-1:0] value,
	input wire logic run,
	output logic match
);

	assign match = run && (count == value);

endmodule

// >>> lfs_sequencer.sv
`timescale 1ns/1ps
`include "lfs_map.svh"

module lfs_sequencer #(
	parameter int TW = `LFS_TIMER_W,
	parameter int NSENS = `LFS_SENSORS,
	parameter int TRIG_DELAY_CYC =
		(`LFS_TRIG_DELAY_NS + `LFS_CLK_PERIOD_NS - 1) / `LFS_CLK_PERIOD_NS
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic trig_in_n,
	input wire logic [TW-1:0] cfg_trig_delay,
	input wire logic [TW-1:0] cfg_precharge,
	input wire logic [TW-1:0] cfg_on_time,
	input wire logic [TW-1:0] cfg_end_offset,
	input wire logic on_flag,
	input wire logic pulse_limit_reached,
	input wire logic [NSENS-1:0] temp_alert_n,
	input wire logic sw_buck_en_n,
	input wire logic sw_shunt_on,
	output logic buck_en_n,
	output logic shunt_on,
	output logic trig_out,
	output logic seq_busy,
	output logic seq_end_event,
	output logic seq_cancel_event
);

	// The lead rounds down to whole cycles, a few ns under nominal.
	localparam int LEAD_CYC = `LFS_TRIG_LEAD_NS / `LFS_CLK_PERIOD_NS;
	localparam logic [TW-1:0] LEAD = TW'(LEAD_CYC);
	localparam logic [TW-1:0] DEF_DELAY = TW'(TRIG_DELAY_CYC);
	localparam logic [TW-1:0] T_START = TW'(`LFS_TIMER_START);

	// =========================================================
	// Reset release
	// =========================================================
	logic rst_meta_q;
	logic rst_n_q;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// =========================================================
	// Helpers
	// =========================================================
	function automatic logic temp_ok_f(input logic [NSENS-1:0] alert_n);
		temp_ok_f = &alert_n;
	endfunction

	logic temp_ok;
	logic go_ok;
	assign temp_ok = temp_ok_f(temp_alert_n);
	assign go_ok = temp_ok_f(temp_alert_n) && on_flag && !pulse_limit_reached;

	// =========================================================
	// Trigger edge
	// =========================================================
	logic trig_prev_q;
	logic trig_prev_d;
	logic trig_fall;

	always_comb begin
		trig_prev_d = trig_in_n;
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			trig_prev_q <= 1'b1;
		end else begin
			trig_prev_q <= trig_prev_d;
		end
	end

	assign trig_fall = trig_prev_q && !trig_in_n;

	// =========================================================
	// Compare values worked out from the configuration
	// =========================================================
	logic [TW-1:0] dly;
	logic [TW-1:0] pre;
	logic [TW-1:0] val_buck;
	logic [TW-1:0] val_trig;
	logic [TW-1:0] val_end;

	// A zero delay selects the default. The precharge is clamped to one cycle under
	// the delay so the buck never needs to start before the trigger; a user
	// must still pick a delay that lets the inductor reach its current.
	always_comb begin
		dly = (cfg_trig_delay == '0) ? DEF_DELAY : cfg_trig_delay;
		pre = (cfg_precharge >= dly) ? dly - T_START : cfg_precharge;
		val_buck = dly - pre;
		val_trig = (dly > LEAD) ? dly - LEAD : T_START;
		val_end = dly + cfg_on_time + cfg_end_offset;
	end

	// =========================================================
	// Sequencer
	// =========================================================
	lfs_pkg::lfs_state_t state_q;
	lfs_pkg::lfs_state_t state_d;
	logic [TW-1:0] timer_q;
	logic [TW-1:0] timer_d;
	logic [TW-1:0] cmp_q [`LFS_CH_NUM];
	logic [TW-1:0] cmp_d [`LFS_CH_NUM];
	logic buck_n_q;
	logic buck_n_d;
	logic shunt_q;
	logic shunt_d;
	logic trig_q;
	logic trig_d;
	logic end_ev_q;
	logic end_ev_d;
	logic cancel_q;
	logic cancel_d;
	logic run;
	logic [`LFS_CH_NUM-1:0] match;
	logic accept;

	assign run = (state_q != lfs_pkg::LFS_IDLE);
	assign accept = (state_q == lfs_pkg::LFS_IDLE) && trig_fall && go_ok;

	// The timer counts sys_clk cycles, so edges land on an 8 ns grid;
	// that is the finest placement this clock allows.
	genvar gi;
	generate
		for (gi = 0; gi < `LFS_CH_NUM; gi++) begin : g_cmp
			lfs_compare #(
				.W(TW)
			) u_cmp (
				.count(timer_q),
				.value(cmp_q[gi]),
				.run(run),
				.match(match[gi])
			);
		end
	endgenerate

	always_comb begin
		state_d = state_q;
		timer_d = run ? timer_q + T_START : timer_q;
		cmp_d = cmp_q;
		buck_n_d = buck_n_q;
		shunt_d = shunt_q;
		trig_d = trig_q;
		end_ev_d = 1'b0;
		cancel_d = 1'b0;
		unique case (state_q)
			lfs_pkg::LFS_IDLE: begin
				// Outputs follow software; heat forces the buck off.
				buck_n_d = sw_buck_en_n || !temp_ok;
				shunt_d = sw_shunt_on;
				trig_d = 1'b0;
				if (accept) begin
					state_d = lfs_pkg::LFS_ARMED;
					timer_d = T_START;
					cmp_d[`LFS_CH_END] = val_end;
					cmp_d[`LFS_CH_BUCK] = val_buck;
					cmp_d[`LFS_CH_SHUNT] = dly;
					cmp_d[`LFS_CH_TRIG] = val_trig;
					shunt_d = 1'b1;
					buck_n_d = `LFS_BUCK_OFF_N;
				end
			end
			lfs_pkg::LFS_ARMED: begin
				if (!go_ok) begin
					state_d = lfs_pkg::LFS_IDLE;
					buck_n_d = `LFS_BUCK_OFF_N;
					shunt_d = `LFS_SHUNT_OFF;
					trig_d = 1'b0;
					cancel_d = 1'b1;
				end else begin
					if (match[`LFS_CH_BUCK]) begin
						buck_n_d = 1'b0;
					end
					if (match[`LFS_CH_TRIG]) begin
						trig_d = 1'b1;
					end
					if (match[`LFS_CH_SHUNT]) begin
						shunt_d = `LFS_SHUNT_OFF;
						state_d = lfs_pkg::LFS_FLASH;
					end
				end
			end
			lfs_pkg::LFS_FLASH: begin
				if (!temp_ok) begin
					state_d = lfs_pkg::LFS_IDLE;
					buck_n_d = `LFS_BUCK_OFF_N;
					trig_d = 1'b0;
					cancel_d = 1'b1;
				end else if (match[`LFS_CH_END]) begin
					buck_n_d = `LFS_BUCK_OFF_N;
					trig_d = 1'b0;
					end_ev_d = 1'b1;
					state_d = lfs_pkg::LFS_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= lfs_pkg::LFS_IDLE;
			timer_q <= '0;
			for (int i = 0; i < `LFS_CH_NUM; i++) begin
				cmp_q[i] <= '0;
			end
			buck_n_q <= `LFS_BUCK_OFF_N;
			shunt_q <= `LFS_SHUNT_OFF;
			trig_q <= 1'b0;
			end_ev_q <= 1'b0;
			cancel_q <= 1'b0;
		end else begin
			state_q <= state_d;
			timer_q <= timer_d;
			cmp_q <= cmp_d;
			buck_n_q <= buck_n_d;
			shunt_q <= shunt_d;
			trig_q <= trig_d;
			end_ev_q <= end_ev_d;
			cancel_q <= cancel_d;
		end
	end

	assign buck_en_n = buck_n_q;
	assign shunt_on = shunt_q;
	assign trig_out = trig_q;
	assign seq_busy = run;
	assign seq_end_event = end_ev_q;
	assign seq_cancel_event = cancel_q;

	// =========================================================
	// Checks
	// =========================================================
	// The timer value equals cycles since the accepting edge, so the
	// moment of each output edge is tied to its latched compare value.
	AST_LATENCY: assert property (@(posedge sys_clk)
		disable iff (!rst_n_q)
		$fell(shunt_q) && state_q == lfs_pkg::LFS_FLASH
		|-> $past(timer_q) == cmp_q[`LFS_CH_SHUNT])
		else $error("flash start not at trigger delay");

	AST_TRIG_LEAD: assert property (@(posedge sys_clk)
		disable iff (!rst_n_q)
		$rose(trig_q) |-> $past(timer_q) == cmp_q[`LFS_CH_TRIG]
		&& cmp_q[`LFS_CH_SHUNT] - cmp_q[`LFS_CH_TRIG] <= LEAD)
		else $error("trigger output lead wrong");

	AST_START: assert property (@(posedge sys_clk)
		disable iff (!rst_n_q)
		accept |=> shunt_q && buck_n_q && timer_q == T_START)
		else $error("sequence start outputs wrong");

	AST_BUCK_ON: assert property (@(posedge sys_clk)
		disable iff (!rst_n_q)
		$fell(buck_n_q) && $past(run)
		|-> $past(timer_q) == cmp_q[`LFS_CH_BUCK]
		&& cmp_q[`LFS_CH_SHUNT] - cmp_q[`LFS_CH_BUCK] <= cfg_precharge)
		else $error("buck enabled at wrong time");

	AST_END: assert property (@(posedge sys_clk)
		disable iff (!rst_n_q)
		state_q == lfs_pkg::LFS_FLASH && temp_ok && match[`LFS_CH_END]
		|=> end_ev_q && buck_n_q && !run ##1 !end_ev_q)
		else $error("end of sequence handling wrong");

	AST_SHUNT_HELD: assert property (@(posedge sys_clk)
		disable iff (!rst_n_q)
		state_q == lfs_pkg::LFS_ARMED && go_ok && !match[`LFS_CH_SHUNT]
		|=> shunt_q)
		else $error("shunt dropped before its match");

	AST_OT_BLOCK: assert property (@(posedge sys_clk)
		disable iff (!rst_n_q)
		state_q == lfs_pkg::LFS_IDLE && !temp_ok |=> !run)
		else $error("flash started while over temperature");

	AST_OT_OFF: assert property (@(posedge sys_clk)
		disable iff (!rst_n_q)
		!temp_ok |=> buck_n_q && !run)
		else $error("power stage left on while over temperature");

	AST_CANCEL: assert property (@(posedge sys_clk)
		disable iff (!rst_n_q)
		state_q == lfs_pkg::LFS_ARMED && (!on_flag || pulse_limit_reached)
		|=> cancel_q && !shunt_q && buck_n_q && !run)
		else $error("sequence not cancelled");

	AST_NO_RETRIG: assert property (@(posedge sys_clk)
		disable iff (!rst_n_q)
		run && trig_fall && $past(run) |=> timer_q == $past(timer_q) + T_START)
		else $error("trigger restarted a running sequence");

	AST_HOLD: assert property (@(posedge sys_clk)
		disable iff (!rst_n_q)
		run && $past(run) |-> $stable(cmp_q[`LFS_CH_END])
		&& $stable(cmp_q[`LFS_CH_BUCK])
		&& $stable(cmp_q[`LFS_CH_SHUNT])
		&& $stable(cmp_q[`LFS_CH_TRIG]))
		else $error("match values changed mid sequence");

	COV_ACCEPT: cover property (@(posedge sys_clk) disable iff (!rst_n_q)
		accept);
	COV_END: cover property (@(posedge sys_clk) disable iff (!rst_n_q)
		end_ev_q);
	COV_CANCEL: cover property (@(posedge sys_clk) disable iff (!rst_n_q)
		cancel_q);
	COV_RETRIG: cover property (@(posedge sys_clk) disable iff (!rst_n_q)
		run && trig_fall);

endmodule

// >>> lfs_led_stage.sv
`timescale 1ns/1ps

// =============================================================
// LED power stage seen by the sequencer
// =============================================================
// The shunt bypasses the string, so light appears only once the buck
// runs and the shunt has let go.
module lfs_led_stage (
	input wire logic sys_clk,
	input wire logic buck_en_n,
	input wire logic shunt_on,
	output logic light,
	output int precharge_cyc
);
	initial precharge_cyc = 0;
	assign light = !buck_en_n && !shunt_on;
	// Inductor charge time is counted while the shunt still carries it.
	always @(posedge sys_clk) begin
		if (!buck_en_n && shunt_on) begin
			precharge_cyc <= precharge_cyc + 1;
		end else if (buck_en_n) begin
			precharge_cyc <= 0;
		end
	end
endmodule

// >>> tb_led_flash_sequencer.sv
`timescale 1ns/1ps

module tb_led_flash_sequencer;
	localparam int TW = 20;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic trig_in_n = 1'b1;
	logic [TW-1:0] cfg_trig_delay = '0, cfg_precharge = '0;
	logic [TW-1:0] cfg_on_time = '0, cfg_end_offset = '0;
	logic on_flag = 1'b1;
	logic pulse_limit_reached = 1'b0;
	logic [3:0] temp_alert_n = 4'hF;
	logic sw_buck_en_n = 1'b1;
	logic sw_shunt_on = 1'b0;
	logic buck_en_n, shunt_on, trig_out, seq_busy, light;
	logic seq_end_event, seq_cancel_event;
	int precharge_cyc, mismatches = 0, n_tests = 0;
	int t_buck, t_trig, t_light, t_shunt, t_end, t_can, p_seen;

	always #4 sys_clk = ~sys_clk;

	lfs_sequencer lfs_sequencer_inst (.sys_clk(sys_clk), .resetn(resetn),
		.trig_in_n(trig_in_n), .cfg_trig_delay(cfg_trig_delay),
		.cfg_precharge(cfg_precharge), .cfg_on_time(cfg_on_time),
		.cfg_end_offset(cfg_end_offset), .on_flag(on_flag),
		.pulse_limit_reached(pulse_limit_reached),
		.temp_alert_n(temp_alert_n), .sw_buck_en_n(sw_buck_en_n),
		.sw_shunt_on(sw_shunt_on), .buck_en_n(buck_en_n),
		.shunt_on(shunt_on), .trig_out(trig_out), .seq_busy(seq_busy),
		.seq_end_event(seq_end_event), .seq_cancel_event(seq_cancel_event));
	lfs_led_stage lfs_led_stage_inst (.sys_clk(sys_clk),
		.buck_en_n(buck_en_n), .shunt_on(shunt_on), .light(light),
		.precharge_cyc(precharge_cyc));

	// =========================================================
	// Checking and reporting
	// =========================================================
	task automatic chk(input string what, input int exp, input int got);
		n_tests++;
		if (exp != got) begin
			mismatches++;
			$display("[ERR] %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	task automatic chkb(input string what, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic finish_test();
		$display("Comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// =========================================================
	// Sequence driver
	// =========================================================
	// A second trigger fall and new settings arrive while busy; both must
	// leave the running sequence untouched. Times count edges from S=1.
	task automatic run(input int d, p, o, f, fk, fc);
		@(posedge sys_clk);
		{t_buck, t_trig, t_light, t_shunt, t_end, t_can} = '0;
		p_seen = -1;
		cfg_trig_delay <= TW'(d);
		cfg_precharge <= TW'(p);
		cfg_on_time <= TW'(o);
		cfg_end_offset <= TW'(f);
		trig_in_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		trig_in_n <= 1'b0;
		for (int k = 1; k < 2000 && t_end == 0 && t_can == 0; k++) begin
			@(posedge sys_clk);
			if (k == 3) begin
				trig_in_n <= 1'b1;
				cfg_trig_delay <= TW'(d + 7);
				cfg_on_time <= TW'(o + 5);
			end
			if (k == 4) trig_in_n <= 1'b0;
			if (k == fc && fk == 1) on_flag <= 1'b0;
			if (k == fc && fk == 2) temp_alert_n <= 4'hB;
			#1;
			if (t_buck == 0 && buck_en_n === 1'b0) t_buck = k;
			if (t_trig == 0 && trig_out === 1'b1) t_trig = k;
			if (t_shunt == 0 && k > 1 && shunt_on === 1'b0) t_shunt = k;
			if (t_light == 0 && light === 1'b1) t_light = k;
			if (t_light == k) p_seen = precharge_cyc;
			if (seq_end_event === 1'b1) t_end = k;
			if (seq_cancel_event === 1'b1) t_can = k;
		end
		chkb("buck after stop", 1'b1, buck_en_n);
		chkb("trig after stop", 1'b0, trig_out);
		chkb("busy after stop", 1'b0, seq_busy);
		@(posedge sys_clk);
		on_flag <= 1'b1;
		temp_alert_n <= 4'hF;
		#1;
		chkb("end pulse length", 1'b0, seq_end_event);
	endtask

	// =========================================================
	// Scenarios
	// =========================================================
	task automatic scen_flash(input int d, p, o, f);
		int dd;
		dd = (d == 0) ? 1250 : d;
		run(d, p, o, f, 0, 0);
		chk("buck on", 1 + dd - p, t_buck);
		chk("light start", 1 + dd, t_light);
		chk("shunt release", 1 + dd, t_shunt);
		chk("trig out", (dd > 812) ? 1 + dd - 812 : 2, t_trig);
		chk("precharge", p, p_seen);
		chk("end", 1 + dd + o + f, t_end);
		$display("flash test done, delay %0d", dd);
	endtask

	task automatic scen_cancel(input int fk, fc);
		run(20, 5, 40, 0, fk, fc);
		chk("no end event", 0, t_end);
		chk("cancel", fc + 1, t_can);
		chkb("shunt on cancel", 1'b0, shunt_on);
		chkb("cancel pulse length", 1'b0, seq_cancel_event);
		$display("cancel test done, kind %0d", fk);
	endtask

	task automatic scen_ignored(input logic [3:0] alert, input logic lim,
		input logic onf);
		int busy_seen;
		busy_seen = 0;
		@(posedge sys_clk);
		sw_buck_en_n <= 1'b0;
		sw_shunt_on <= 1'b1;
		temp_alert_n <= alert;
		pulse_limit_reached <= lim;
		on_flag <= onf;
		trig_in_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		trig_in_n <= 1'b0;
		repeat (30) begin
			@(posedge sys_clk);
			#1;
			if (seq_busy !== 1'b0) busy_seen++;
		end
		chk("busy cycles", 0, busy_seen);
		chkb("idle buck", alert != 4'hF, buck_en_n);
		if (alert == 4'hF) chkb("idle shunt", 1'b1, shunt_on);
		@(posedge sys_clk);
		sw_buck_en_n <= 1'b1;
		sw_shunt_on <= 1'b0;
		temp_alert_n <= 4'hF;
		pulse_limit_reached <= 1'b0;
		on_flag <= 1'b1;
		repeat (3) @(posedge sys_clk);
		$display("ignored trigger test done");
	endtask

	// A reset in mid-sequence must drop the power stage at once.
	task automatic scen_reset();
		@(posedge sys_clk);
		cfg_trig_delay <= TW'(20);
		cfg_precharge <= TW'(5);
		cfg_on_time <= TW'(10);
		cfg_end_offset <= '0;
		trig_in_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		trig_in_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		chkb("busy before reset", 1'b1, seq_busy);
		chkb("shunt before reset", 1'b1, shunt_on);
		@(posedge sys_clk);
		resetn <= 1'b0;
		trig_in_n <= 1'b1;
		#1;
		chkb("busy in reset", 1'b0, seq_busy);
		chkb("shunt in reset", 1'b0, shunt_on);
		chkb("buck in reset", 1'b1, buck_en_n);
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		#1;
		chkb("idle after reset", 1'b0, seq_busy);
		$display("reset test done");
	endtask

	initial begin
		repeat (19) @(posedge sys_clk);
		#1;
		chkb("reset buck", 1'b1, buck_en_n);
		chkb("reset shunt", 1'b0, shunt_on);
		chkb("reset busy", 1'b0, seq_busy);
		@(posedge sys_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		scen_flash(20, 5, 10, 3);
		scen_flash(20, 19, 1, 0);
		scen_flash(0, 100, 125, 0);
		scen_flash(900, 1, 1, 0);
		scen_cancel(1, 5);
		scen_cancel(2, 5);
		scen_cancel(2, 30);
		for (int i = 0; i < 4; i++) begin
			scen_ignored(~(4'h1 << i), 1'b0, 1'b1);
		end
		scen_ignored(4'hF, 1'b1, 1'b1);
		scen_ignored(4'hF, 1'b0, 1'b0);
		scen_reset();
		finish_test();
	end

	// The longest run is about 1400 cycles; this bound leaves wide margin.
	initial begin
		#200000;
		mismatches++;
		$display("Watchdog expired");
		finish_test();
	end
endmodule
